// >>> swc_defines.svh
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH

// ****************************************************************
// Register indices; byte address is four times the index.
// ****************************************************************
`define SWC_IDX_PWR    8'h01
`define SWC_IDX_TPC    8'h70
`define SWC_IDX_KS1    8'hc0
`define SWC_IDX_KS2    8'hc1
`define SWC_IDX_KCODE  8'hc2
`define SWC_IDX_IMASK  8'hf0
`define SWC_IDX_ISTAT  8'hf1

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define SWC_B_SLEEP    1
`define SWC_B_TP_EN    7
`define SWC_B_TP_WAKE  3
`define SWC_B_KS_EN    7
`define SWC_B_KS_WAKE  7
`define SWC_ST_READY   0
`define SWC_ST_TOUCH   1
`define SWC_ST_KEY     2
`define SWC_ST_KCAP    3
`define SWC_RST_BYTE   8'h00
`define SWC_RESP_OKAY  2'h0
`define SWC_RESP_SLV   2'h2

// ****************************************************************
// Timing.
// ****************************************************************
`define SWC_CLK_HZ     40000000
`define SWC_SETTLE_MS  10
`define SWC_SETTLE_CYC ((`SWC_CLK_HZ / 1000) * `SWC_SETTLE_MS)

`endif

// >>> swc_pkg.sv
`include "swc_defines.svh"

package swc_pkg;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_SETTLE} swc_state_t;

  typedef logic [7:0] swc_idx_t;

  function automatic swc_idx_t swc_index(input logic [31:0] addr);
    return addr[9:2];
  endfunction

  function automatic logic swc_mapped(input swc_idx_t idx);
    return (idx == `SWC_IDX_PWR) || (idx == `SWC_IDX_TPC) ||
           (idx == `SWC_IDX_KS1) || (idx == `SWC_IDX_KS2) ||
           (idx == `SWC_IDX_KCODE) || (idx == `SWC_IDX_IMASK) ||
           (idx == `SWC_IDX_ISTAT);
  endfunction

endpackage

// >>> swc_sync.sv
`timescale 1ns/1ps

module swc_sync #(
  parameter int W = 2
) (
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  // Data.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// >>> swc_wake_qual.sv
`timescale 1ns/1ps

module swc_wake_qual (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic ce,
  // Synchronised pins.
  input  wire logic touch_s,
  input  wire logic key_s,
  // Qualifiers.
  input  wire logic tp_armed,
  input  wire logic ks_armed,
  input  wire logic asleep,
  // Events.
  output logic      touch_rise,
  output logic      key_rise,
  output logic      touch_wake,
  output logic      key_wake
);

  logic touch_prev_reg;
  logic key_prev_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      touch_prev_reg <= 1'b0;
      key_prev_reg   <= 1'b0;
    end else if (ce) begin
      touch_prev_reg <= touch_s;
      key_prev_reg   <= key_s;
    end
  end

  assign touch_rise = touch_s && !touch_prev_reg;
  assign key_rise   = key_s && !key_prev_reg;
  // A source wakes only when both of its enables are set.
  assign touch_wake = asleep && tp_armed && touch_rise; // RQ4
  assign key_wake   = asleep && ks_armed && key_rise; // RQ7

endmodule

// >>> swc_top.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "swc_defines.svh"

// Notes on behaviour
// [RQ1] Sleep stops oscillator, display memory, font ROM; host writes ignored except to the sleep bit.
// [RQ2] Pulse outputs keep their register-defined state through sleep.
// [RQ3] Sleep bit 1 enters sleep; host writing 0 wakes the device.
// [RQ4] Touch wakes only with touch enable and touch wake enable both set.
// [RQ5] Host selects wait-for-touch state before sleep in manual mode.
// [RQ6] Host sets key-scan enable and key wake enable before sleep.
// [RQ7] Any key press wakes the device when key wake is armed.
// [RQ8] The waking key press is not captured as a key code.
// [RQ9] Host waits about 10 ms after wake before accessing the device.
// [RQ10] Fixed pin levels are driven while the device is not running.
// [RQ11] Key wake sets a status bit that can raise the interrupt.
// [RQ12] Wake sources are ORed; first one clears sleep, restarts oscillator.
module swc_top
  import swc_pkg::*;
#(
  parameter int SETTLE_CYC = `SWC_SETTLE_CYC
) (
  // Clock, reset, enable.
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // AXI4-Lite write.
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_awaddr,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  output logic [1:0]       s_bresp,
  // AXI4-Lite read.
  input  wire logic        s_arvalid,
  output logic             s_arready,
  input  wire logic [31:0] s_araddr,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  // Wake pins and key-scan code.
  input  wire logic        touch_event,
  input  wire logic        key_press,
  input  wire logic [7:0]  key_code,
  // Core-side pin values.
  input  wire logic        core_wait_n,
  input  wire logic [5:0]  core_gpio,
  input  wire logic [18:0] core_mem_addr,
  input  wire logic        core_ram_oe_n,
  input  wire logic        core_ram_cs_n,
  input  wire logic        core_ram_wr_n,
  input  wire logic        core_rom_cs_n,
  input  wire logic [15:0] core_pixel,
  input  wire logic        core_vsync,
  input  wire logic        core_hsync,
  input  wire logic        core_pclk,
  input  wire logic        core_de,
  input  wire logic        core_pulse_one,
  input  wire logic        core_pulse_two,
  // Pins.
  output logic             wait_n,
  output logic             int_n,
  output logic [5:0]       gpio,
  output logic [18:0]      external_memory_address,
  output logic             ram_oe_n,
  output logic             ram_cs_n,
  output logic             ram_wr_n,
  output logic             rom_cs_n,
  output logic [15:0]      pixel_data_bus,
  output logic             vsync,
  output logic             hsync,
  output logic             pclk,
  output logic             de,
  output logic             pulse_output_one,
  output logic             pulse_output_two,
  // Power controls and interrupt.
  output logic             osc_en,
  output logic             dram_en,
  output logic             font_rom_en,
  output logic             irq
);

  localparam int CW = $clog2(SETTLE_CYC + 1);

  swc_state_t state;
  logic [CW-1:0] settle_cnt;
  logic [7:0]    tpc_reg, ks1_reg, kcode_reg, imask_reg, istat_reg;
  logic [7:0]    istat_next;
  logic          sleep_reg;
  logic          ks2_wake_reg;
  logic [1:0]    ks2_long_reg;
  logic [1:0]    hits_reg;
  logic          run_reg;
  logic          aw_full, w_full;
  swc_idx_t      aw_idx, r_idx;
  logic [7:0]    w_byte;
  logic          w_lane;
  logic          wr_go, rd_go, wr_ok;
  logic [1:0]    sync_q;
  logic          touch_rise, key_rise, touch_wake, key_wake;
  logic          wake_any, settle_done;

  // ****************************************************************
  // AXI4-Lite slave.
  // ****************************************************************
  assign s_awready = ce && !aw_full;
  assign s_wready  = ce && !w_full;
  assign s_arready = ce && !s_rvalid;
  assign wr_go     = ce && aw_full && w_full && !s_bvalid;
  assign rd_go     = s_arvalid && s_arready;
  assign r_idx     = swc_index(s_araddr);
  // While asleep only the sleep bit listens, so a stray write cannot
  // reconfigure the wake logic behind the host's back.
  assign wr_ok = wr_go && w_lane && swc_mapped(aw_idx) &&
                 (state != ST_SLEEP || aw_idx == `SWC_IDX_PWR); // RQ1

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_idx  <= '0;
      w_byte  <= '0;
      w_lane  <= 1'b0;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_full <= 1'b1;
        aw_idx  <= swc_index(s_awaddr);
      end else if (wr_go) begin
        aw_full <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_full <= 1'b1;
        w_byte <= s_wdata[7:0];
        w_lane <= s_wstrb[0];
      end else if (wr_go) begin
        w_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_bvalid <= 1'b0;
      s_bresp  <= `SWC_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= swc_mapped(aw_idx) ? `SWC_RESP_OKAY : `SWC_RESP_SLV;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= `SWC_RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rresp  <= swc_mapped(r_idx) ? `SWC_RESP_OKAY : `SWC_RESP_SLV;
        unique case (r_idx)
          `SWC_IDX_PWR: s_rdata <= {30'h0, sleep_reg, 1'b0};
          `SWC_IDX_TPC: s_rdata <= {24'h0, tpc_reg};
          `SWC_IDX_KS1: s_rdata <= {24'h0, ks1_reg};
          `SWC_IDX_KS2:
            s_rdata <= {24'h0, ks2_wake_reg, 3'h0, ks2_long_reg, hits_reg};
          `SWC_IDX_KCODE: s_rdata <= {24'h0, kcode_reg};
          `SWC_IDX_IMASK: s_rdata <= {24'h0, imask_reg};
          `SWC_IDX_ISTAT: s_rdata <= {24'h0, istat_reg};
          default: s_rdata <= '0;
        endcase
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tpc_reg      <= `SWC_RST_BYTE;
      ks1_reg      <= `SWC_RST_BYTE;
      ks2_wake_reg <= 1'b0;
      ks2_long_reg <= 2'h0;
      imask_reg    <= `SWC_RST_BYTE;
    end else if (ce && wr_ok) begin
      if (aw_idx == `SWC_IDX_TPC) tpc_reg <= w_byte;
      if (aw_idx == `SWC_IDX_KS1) ks1_reg <= w_byte;
      if (aw_idx == `SWC_IDX_KS2) begin
        ks2_wake_reg <= w_byte[`SWC_B_KS_WAKE];
        ks2_long_reg <= w_byte[3:2];
      end
      if (aw_idx == `SWC_IDX_IMASK) imask_reg <= w_byte;
    end
  end

  // The hardware clear beats a host write of 1 in the same cycle, so a
  // wake can never be swallowed by a racing sleep request.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_reg <= 1'b0;
    end else if (ce) begin
      if (wake_any) begin
        sleep_reg <= 1'b0; // RQ12
      end else if (wr_ok && aw_idx == `SWC_IDX_PWR) begin
        sleep_reg <= w_byte[`SWC_B_SLEEP]; // RQ3
      end
    end
  end

  // ****************************************************************
  // Wake sources.
  // ****************************************************************
  swc_sync #(.W(2)) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ce     (ce),
    .d      ({key_press, touch_event}),
    .q      (sync_q)
  );

  swc_wake_qual u_qual (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .ce         (ce),
    .touch_s    (sync_q[0]),
    .key_s      (sync_q[1]),
    .tp_armed   (tpc_reg[`SWC_B_TP_EN] && tpc_reg[`SWC_B_TP_WAKE]),
    .ks_armed   (ks1_reg[`SWC_B_KS_EN] && ks2_wake_reg),
    .asleep     (state == ST_SLEEP),
    .touch_rise (touch_rise),
    .key_rise   (key_rise),
    .touch_wake (touch_wake),
    .key_wake   (key_wake)
  );

  assign wake_any = ce && (touch_wake || key_wake); // RQ12

  // ****************************************************************
  // Sleep sequencer.
  // ****************************************************************
  assign settle_done = settle_cnt == CW'(SETTLE_CYC - 1);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_RUN;
      settle_cnt <= '0;
    end else if (ce) begin
      unique case (state)
        ST_RUN: begin
          if (sleep_reg) state <= ST_SLEEP; // RQ3
        end
        ST_SLEEP: begin
          settle_cnt <= '0;
          if (!sleep_reg || touch_wake || key_wake) begin
            state <= ST_SETTLE; // RQ12
          end
        end
        ST_SETTLE: begin
          settle_cnt <= settle_cnt + CW'(1);
          if (settle_done) state <= ST_RUN;
        end
      endcase
    end
  end

  // Oscillator and memories restart one cycle after the settle wait has begun, since run_reg is registered from state.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run_reg <= 1'b1;
    end else if (ce) begin
      run_reg <= state != ST_SLEEP; // RQ1
    end
  end

  assign osc_en      = run_reg;
  assign dram_en     = run_reg;
  assign font_rom_en = run_reg;

  // ****************************************************************
  // Key capture and interrupt status.
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      kcode_reg <= `SWC_RST_BYTE;
      hits_reg  <= 2'h0;
    end else if (ce) begin
      if (state == ST_RUN && key_rise && ks1_reg[`SWC_B_KS_EN]) begin
        kcode_reg <= key_code; // RQ8
        if (hits_reg != 2'h3) hits_reg <= hits_reg + 2'h1;
      end else if (rd_go && r_idx == `SWC_IDX_KCODE) begin
        hits_reg <= 2'h0;
      end
    end
  end

  always_comb begin
    istat_next = istat_reg;
    if (rd_go && r_idx == `SWC_IDX_ISTAT) istat_next = '0;
    if (state == ST_SETTLE && settle_done) begin
      istat_next[`SWC_ST_READY] = 1'b1;
    end
    if (touch_wake) istat_next[`SWC_ST_TOUCH] = 1'b1;
    if (key_wake) istat_next[`SWC_ST_KEY] = 1'b1; // RQ11
    if (state == ST_RUN && key_rise && ks1_reg[`SWC_B_KS_EN]) begin
      istat_next[`SWC_ST_KCAP] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      istat_reg <= `SWC_RST_BYTE;
      irq       <= 1'b0;
    end else if (ce) begin
      istat_reg <= istat_next;
      irq       <= |(istat_next & imask_reg); // RQ11
    end
  end

  // ****************************************************************
  // Pin levels.
  // ****************************************************************
  // Safe levels hold through the settle wait too, since the pixel and
  // memory timing is not trustworthy until the PLL has locked.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wait_n <= 1'b1;
      int_n  <= 1'b1;
      gpio   <= '0;
      external_memory_address <= '0;
      ram_oe_n <= 1'b0;
      ram_cs_n <= 1'b1;
      ram_wr_n <= 1'b1;
      rom_cs_n <= 1'b1;
      pixel_data_bus <= '0;
      vsync  <= 1'b1;
      hsync  <= 1'b1;
      pclk   <= 1'b1;
      de     <= 1'b1;
    end else if (ce) begin
      if (state != ST_RUN) begin
        wait_n <= 1'b1; // RQ10
        int_n  <= 1'b1;
        gpio   <= '0;
        external_memory_address <= '0;
        ram_oe_n <= 1'b0;
        ram_cs_n <= 1'b1;
        ram_wr_n <= 1'b1;
        rom_cs_n <= 1'b1;
        pixel_data_bus <= '0;
        vsync  <= 1'b1;
        hsync  <= 1'b1;
        pclk   <= 1'b1;
        de     <= 1'b1;
      end else begin
        wait_n <= core_wait_n;
        int_n  <= !(|(istat_next & imask_reg));
        gpio   <= core_gpio;
        external_memory_address <= core_mem_addr;
        ram_oe_n <= core_ram_oe_n;
        ram_cs_n <= core_ram_cs_n;
        ram_wr_n <= core_ram_wr_n;
        rom_cs_n <= core_rom_cs_n;
        pixel_data_bus <= core_pixel;
        vsync  <= core_vsync;
        hsync  <= core_hsync;
        pclk   <= core_pclk;
        de     <= core_de;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_output_one <= 1'b0;
      pulse_output_two <= 1'b0;
    end else if (ce) begin
      pulse_output_one <= core_pulse_one; // RQ2
      pulse_output_two <= core_pulse_two;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  sequence s_sleep_wr;
    ce && wr_ok && aw_idx == `SWC_IDX_PWR && w_byte[`SWC_B_SLEEP] &&
    state == ST_RUN ##1 ce;
  endsequence

  sequence s_wake_wr;
    ce && wr_ok && aw_idx == `SWC_IDX_PWR && !w_byte[`SWC_B_SLEEP] &&
    state == ST_SLEEP && !wake_any ##1 ce;
  endsequence

  property p_osc_off;
    @(posedge mclk) disable iff (!arst_n)
      $past(ce && state == ST_SLEEP) |-> !osc_en && !dram_en;
  endproperty
  a_osc_off: assert property (p_osc_off) // RQ1
    else $error("clocks not stopped in sleep");

  property p_ignore;
    @(posedge mclk) disable iff (!arst_n)
      (ce && wr_go && state == ST_SLEEP && aw_idx == `SWC_IDX_KS1)
      |=> $stable(ks1_reg);
  endproperty
  a_ignore: assert property (p_ignore) // RQ1
    else $error("write taken during sleep");

  property p_pulse;
    @(posedge mclk) disable iff (!arst_n)
      $past(ce) |-> pulse_output_one == $past(core_pulse_one);
  endproperty
  a_pulse: assert property (p_pulse) // RQ2
    else $error("pulse output altered");

  property p_enter;
    @(posedge mclk) disable iff (!arst_n)
      s_sleep_wr |=> state == ST_SLEEP;
  endproperty
  a_enter: assert property (p_enter) // RQ3
    else $error("sleep not entered");

  property p_wake_wr;
    @(posedge mclk) disable iff (!arst_n)
      s_wake_wr |=> state == ST_SETTLE;
  endproperty
  a_wake_wr: assert property (p_wake_wr) // RQ3
    else $error("register wake failed");

  property p_touch;
    @(posedge mclk) disable iff (!arst_n)
      (ce && touch_wake) |=> state == ST_SETTLE && !sleep_reg;
  endproperty
  a_touch: assert property (p_touch) // RQ4
    else $error("touch wake failed");

  property p_key;
    @(posedge mclk) disable iff (!arst_n)
      (ce && key_wake) |=> state == ST_SETTLE && istat_reg[`SWC_ST_KEY];
  endproperty
  a_key: assert property (p_key) // RQ7
    else $error("key wake failed");

  property p_nocap;
    @(posedge mclk) disable iff (!arst_n)
      (ce && key_wake) |=> $stable(kcode_reg) && $stable(hits_reg);
  endproperty
  a_nocap: assert property (p_nocap) // RQ8
    else $error("waking key captured");

  property p_levels;
    @(posedge mclk) disable iff (!arst_n)
      $past(ce && state != ST_RUN) |-> wait_n && int_n && gpio == '0 &&
      pixel_data_bus == '0 && !ram_oe_n && ram_cs_n && pclk && de;
  endproperty
  a_levels: assert property (p_levels) // RQ10
    else $error("sleep pin levels wrong");

  property p_irq;
    @(posedge mclk) disable iff (!arst_n)
      $past(ce) |-> irq == |(istat_reg & $past(imask_reg));
  endproperty
  a_irq: assert property (p_irq) // RQ11
    else $error("interrupt level wrong");

  property p_resume;
    @(posedge mclk) disable iff (!arst_n)
      (ce && state == ST_SETTLE && settle_done) |=>
      state == ST_RUN && istat_reg[`SWC_ST_READY] && osc_en;
  endproperty
  a_resume: assert property (p_resume) // RQ12
    else $error("resume after settle failed");

endmodule

// >>> swc_host.sv
`timescale 1ns/1ps

// ****************************************************************
// Host model: one write and one read at most, each held until taken.
// ****************************************************************
module swc_host #(
  parameter int SETTLE_CYC = 8
) (
  // Clock.
  input  wire logic        mclk,
  // Write channels.
  output logic             s_awvalid,
  input  wire logic        s_awready,
  output logic [31:0]      s_awaddr,
  output logic             s_wvalid,
  input  wire logic        s_wready,
  output logic [31:0]      s_wdata,
  output logic [3:0]       s_wstrb,
  input  wire logic        s_bvalid,
  output logic             s_bready,
  input  wire logic [1:0]  s_bresp,
  // Read channels.
  output logic             s_arvalid,
  input  wire logic        s_arready,
  output logic [31:0]      s_araddr,
  input  wire logic        s_rvalid,
  output logic             s_rready,
  input  wire logic [31:0] s_rdata,
  input  wire logic [1:0]  s_rresp
);
  initial begin
    {s_awvalid, s_awaddr, s_wvalid, s_wdata, s_wstrb, s_bready} = '0;
    {s_arvalid, s_araddr, s_rready} = '0;
  end

  // Sleep entry, wake and all wake enables are written here.
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge mclk);
    s_awvalid <= 1'b1;
    s_awaddr  <= a;
    s_wvalid  <= 1'b1;
    s_wdata   <= {24'h0, d};
    s_wstrb   <= 4'h1;
    s_bready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid && s_bready) break;
    end
    r = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge mclk);
    s_arvalid <= 1'b1;
    s_araddr  <= a;
    s_rready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && s_rready) break;
    end
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask

  // Touch runs in auto mode, so no wait-for-touch state is needed.
  // The oscillator needs time to settle; no access meanwhile.
  task automatic settle();
    repeat (SETTLE_CYC + 4) @(posedge mclk);
  endtask
endmodule

// >>> sleep_wakeup_controller_bench.sv
`timescale 1ns/1ps

module sleep_wakeup_controller_bench;
  logic        mclk, arst_n, ce, touch_event, key_press;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, rdat;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, resp;
  logic [7:0]  key_code;
  logic        core_wait_n, core_int_unused, core_ram_oe_n, core_ram_cs_n;
  logic        core_ram_wr_n, core_rom_cs_n, core_vsync, core_hsync;
  logic        core_pclk, core_de, core_pulse_one, core_pulse_two;
  logic [5:0]  core_gpio, gpio;
  logic [18:0] core_mem_addr, external_memory_address;
  logic [15:0] core_pixel, pixel_data_bus;
  logic        wait_n, int_n, ram_oe_n, ram_cs_n, ram_wr_n, rom_cs_n;
  logic        vsync, hsync, pclk, de, pulse_output_one, pulse_output_two;
  logic        osc_en, dram_en, font_rom_en, irq;
  logic [50:0] core_v, pins;
  int          bad_count, samples_checked, cyc;

  localparam logic [50:0] SLP = {2'h3, 25'h0, 4'h7, 16'h0, 4'hf};
  localparam logic [50:0] RUN = ~SLP | {2'h1, 49'h0};

  assign {core_wait_n, core_int_unused, core_gpio, core_mem_addr,
          core_ram_oe_n, core_ram_cs_n, core_ram_wr_n, core_rom_cs_n,
          core_pixel, core_vsync, core_hsync, core_pclk, core_de} = core_v;
  assign pins = {wait_n, int_n, gpio, external_memory_address, ram_oe_n,
                 ram_cs_n, ram_wr_n, rom_cs_n, pixel_data_bus, vsync,
                 hsync, pclk, de};

  swc_top #(.SETTLE_CYC(8)) uut (.*);
  swc_host #(.SETTLE_CYC(8)) host (.*);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ****************************************************************
  // Checking and closing.
  // ****************************************************************
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    host.wr(a, d, resp);
    chk(resp, 2'h0);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    host.rd(a, rdat, resp);
    chk({rdat, 30'h0, resp}, {exp, 32'h0});
  endtask

  // A bounded wait, so a wake that never comes shows as a mismatch.
  task automatic wait_osc(input logic v);
    int n;
    n = 0;
    while (osc_en !== v && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk(osc_en, v);
  endtask

  task automatic nap();
    wr(32'h004, 8'h02);
    wait_osc(1'b0);
    @(posedge mclk);
  endtask

  task automatic pin_pulse(input bit t);
    if (t) touch_event <= 1'b1;
    else key_press <= 1'b1;
    repeat (4) @(posedge mclk);
    touch_event <= 1'b0;
    key_press   <= 1'b0;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic s_regs();
    rdc(32'h004, 32'h0);
    wr(32'h1c0, 8'h88);
    rdc(32'h1c0, 32'h88);
    host.rd(32'h010, rdat, resp);
    chk(resp, 2'h2);
    ce <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({s_awready, s_wready, s_arready}, 3'h0);
    ce <= 1'b1;
  endtask

  task automatic s_sleep();
    nap();
    chk({dram_en, font_rom_en}, 2'h0);
    chk(pins, SLP);
    core_pulse_one <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({pulse_output_one, pulse_output_two}, 2'h2);
    wr(32'h300, 8'hff);
    wr(32'h004, 8'h00);
    wait_osc(1'b1);
    host.settle();
    rdc(32'h300, 32'h0);
    chk(pins, RUN);
    rdc(32'h3c4, 32'h1);
  endtask

  task automatic s_touch();
    wr(32'h1c0, 8'h80);
    nap();
    pin_pulse(1'b1);
    repeat (10) @(posedge mclk);
    chk(osc_en, 1'b0);
    wr(32'h004, 8'h00);
    wait_osc(1'b1);
    host.settle();
    rdc(32'h3c4, 32'h1);
    wr(32'h1c0, 8'h88);
    nap();
    pin_pulse(1'b1);
    wait_osc(1'b1);
    host.settle();
    rdc(32'h3c4, 32'h3);
  endtask

  task automatic s_key();
    wr(32'h300, 8'h80);
    wr(32'h304, 8'h80);
    wr(32'h3c0, 8'h04);
    key_code <= 8'h23;
    nap();
    pin_pulse(1'b0);
    wait_osc(1'b1);
    @(posedge mclk);
    chk(irq, 1'b1);
    host.settle();
    rdc(32'h304, 32'h80);
    rdc(32'h308, 32'h0);
    rdc(32'h3c4, 32'h5);
    repeat (2) @(posedge mclk);
    chk({irq, int_n}, 2'h1);
    key_code <= 8'h14;
    pin_pulse(1'b0);
    repeat (6) @(posedge mclk);
    rdc(32'h304, 32'h81);
    rdc(32'h3c4, 32'h8);
    rdc(32'h308, 32'h14);
  endtask

  initial begin
    {arst_n, touch_event, key_press, key_code} = '0;
    {core_pulse_one, core_pulse_two, bad_count, samples_checked, cyc} = '0;
    ce     = 1'b1;
    core_v = ~SLP;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    s_regs();
    s_sleep();
    s_touch();
    s_key();
    end_sim();
  end
endmodule
